// *** hw/uab_autobaud.sv ***
// Auto-baud measurement unit with its rate generator and AHB-Lite register slave.
//
// Contract
// [R01] In auto-baud mode the receive line times the generator counter over a 0x55 character.
// [R02] Setting the enable bit starts calibration and holds the receiver idle throughout.
// [R03] Counting starts at the first rising receive edge after the start bit, on the slow clock.
// [R04] Counting stops at the fifth rising edge and the period stays in the divisor pair.
// [R05] At completion the enable bit clears itself and the receive flag sets.
// [R06] Reading the receive data register clears the receive flag; software discards the data.
// [R07] During measurement both divisor bytes form one 16-bit counter whatever the wide select.
// [R08] The measuring clock is base/8: oscillator/512, /128 or /32 by the select pair.
// [R09] The base clock is oscillator/64, /16 with one select set, or /4 with both set.
// [R10] The counter starts at one; software subtracts one afterwards.
// [R11] Software may check a zero high byte to confirm the low byte did not overflow.
// [R12] With wake-on-edge set too, measurement runs on the byte after the break.
// [R13] The overflow flag sets when the counter passes its maximum before the fifth edge.
// [R14] After overflow counting continues to the fifth edge, then flag sets and enable clears.
// [R15] The overflow flag clears only by software write, never by itself at completion.
// [R16] The overflow flag ignores a clear while enable is still set.
// [R17] The bit rate equals the base clock divided by the divisor plus one.
`timescale 1ns/1ns
`include "uab_params.svh"

module uab_autobaud
  import uab_pkg::*;
#(
  // Width of the divisor pair; the measuring counter spans all of it.
  parameter int DIV_W = 16
)
(
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Serial line and receiver side.
  input wire logic rx_pin,
  output logic rx_hold,
  output logic rate_tick,
  // Interrupt.
  output logic irq
);

  uab_ctrl_type ctrl_ff;
  uab_state_type state_ff;
  logic [DIV_W-1:0] div_ff;
  logic [2:0] edges_ff;
  logic rif_ff;
  logic [`UAB_IRQ_W-1:0] istat_ff;
  logic [`UAB_IRQ_W-1:0] imask_ff;
  logic [31:0] hrdata_ff;
  logic hready_ff;
  logic irq_ff;
  logic hold_ff;
  logic tick_ff;
  logic [`UAB_PRE_W-1:0] pre_ff;
  logic [DIV_W-1:0] rate_cnt_ff;
  logic rx_s1_ff;
  logic rx_s2_ff;
  logic rx_q_ff;
  logic wr_ff;
  logic [5:0] wa_ff;

  // Prescaler masks for the base clock and for the measuring clock.
  function automatic logic [`UAB_PRE_W-1:0] pre_mask(input logic wide, input logic speed,
                                                     input logic slow);
    logic [`UAB_PRE_W-1:0] m;
    m = 9'h000;
    if (wide && speed) begin
      m = slow ? `UAB_ABD_M11 : `UAB_BASE_M11;
    end else if (wide || speed) begin
      m = slow ? `UAB_ABD_M01 : `UAB_BASE_M01;
    end else begin
      m = slow ? `UAB_ABD_M00 : `UAB_BASE_M00;
    end
    return m;
  endfunction : pre_mask

  logic [`UAB_PRE_W-1:0] base_m;
  logic [`UAB_PRE_W-1:0] abd_m;
  logic base_tick;
  logic abd_tick;
  assign base_m = pre_mask(ctrl_ff.wide, ctrl_ff.speed, 1'b0);
  assign abd_m = pre_mask(ctrl_ff.wide, ctrl_ff.speed, 1'b1);
  assign base_tick = (pre_ff & base_m) == base_m; // see [R09]
  assign abd_tick = (pre_ff & abd_m) == abd_m; // see [R08]

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_ff <= 9'h000;
    end else begin
      pre_ff <= pre_ff + 9'h001;
    end
  end

  // Receive line synchroniser and edge detection.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_q_ff <= 1'b1;
    end else begin
      rx_s1_ff <= rx_pin;
      rx_s2_ff <= rx_s1_ff;
      rx_q_ff <= rx_s2_ff;
    end
  end

  logic rx_rise;
  logic rx_fall;
  assign rx_rise = rx_s2_ff && !rx_q_ff;
  assign rx_fall = !rx_s2_ff && rx_q_ff;

  // AHB-Lite address phase decode.
  logic acc;
  logic rd_acc;
  logic [5:0] ra;
  assign acc = hsel && hready && htrans[1];
  assign rd_acc = acc && !hwrite;
  assign ra = haddr[5:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_ff <= 1'b0;
      wa_ff <= 6'h00;
    end else begin
      wr_ff <= acc && hwrite && haddr[31:6] == 26'h0;
      wa_ff <= ra;
    end
  end

  logic wr_ctrl;
  logic wr_div;
  logic wr_istat;
  logic wr_imask;
  logic rd_rx;
  assign wr_ctrl = wr_ff && wa_ff == `UAB_OFS_CTRL;
  assign wr_div = wr_ff && wa_ff == `UAB_OFS_DIV;
  assign wr_istat = wr_ff && wa_ff == `UAB_OFS_ISTAT;
  assign wr_imask = wr_ff && wa_ff == `UAB_OFS_IMASK;
  assign rd_rx = rd_acc && haddr[31:6] == 26'h0 && ra == `UAB_OFS_RXDATA;

  // Measurement sequencer.
  logic done;
  logic abort;
  assign done = state_ff == UAB_COUNT && rx_rise && edges_ff == 3'h1; // see [R04]
  assign abort = wr_ctrl && !hwdata[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= UAB_IDLE;
      edges_ff <= 3'h0;
    end else if (abort || !ctrl_ff.en) begin
      state_ff <= UAB_IDLE;
    end else begin
      case (state_ff)
        UAB_IDLE: begin
          state_ff <= ctrl_ff.wake ? UAB_WAKE_FALL : UAB_START; // see [R12]
        end
        UAB_WAKE_FALL: begin
          if (rx_fall) begin
            state_ff <= UAB_WAKE_RISE;
          end
        end
        UAB_WAKE_RISE: begin
          if (rx_rise) begin
            state_ff <= UAB_START;
          end
        end
        UAB_START: begin
          if (rx_fall) begin
            state_ff <= UAB_FIRST_RISE;
          end
        end
        UAB_FIRST_RISE: begin
          if (rx_rise) begin
            state_ff <= UAB_COUNT; // see [R03]
            edges_ff <= `UAB_EDGES_LEFT;
          end
        end
        UAB_COUNT: begin
          if (rx_rise) begin
            edges_ff <= edges_ff - 3'h1;
            if (edges_ff == 3'h1) begin
              state_ff <= UAB_IDLE; // see [R14]
            end
          end
        end
        default: begin
          state_ff <= UAB_IDLE;
        end
      endcase
    end
  end

  // Divisor pair: a register normally, one 16-bit counter while measuring.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_ff <= DIV_W'(`UAB_DIV_RST);
    end else if (state_ff == UAB_FIRST_RISE && rx_rise && ctrl_ff.en) begin
      div_ff <= DIV_W'(`UAB_DIV_START); // see [R10]
    end else if (state_ff == UAB_COUNT && !done && abd_tick) begin
      div_ff <= div_ff + DIV_W'(1); // see [R01] see [R07]
    end else if (wr_div && !ctrl_ff.en) begin
      div_ff <= hwdata[DIV_W-1:0];
    end
  end

  logic ovf_evt;
  assign ovf_evt = state_ff == UAB_COUNT && !done && abd_tick && div_ff == {DIV_W{1'b1}};

  // Control register; the overflow flag set wins over any clear.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_ff <= `UAB_CTRL_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff.wake <= hwdata[1];
        ctrl_ff.wide <= hwdata[2];
        ctrl_ff.speed <= hwdata[3];
      end
      if (done) begin
        ctrl_ff.en <= 1'b0; // see [R05]
      end else if (wr_ctrl) begin
        ctrl_ff.en <= hwdata[0]; // see [R02]
      end
      if (ovf_evt) begin
        ctrl_ff.ovf <= 1'b1; // see [R13]
      end else if (wr_ctrl && !hwdata[4] && !ctrl_ff.en) begin
        ctrl_ff.ovf <= 1'b0; // see [R15] see [R16]
      end
    end
  end

  // Receive flag: set at completion, cleared by reading the data register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rif_ff <= 1'b0;
    end else if (done) begin
      rif_ff <= 1'b1; // see [R05]
    end else if (rd_rx) begin
      rif_ff <= 1'b0; // see [R06]
    end
  end

  // Interrupt status, write one to clear, set wins.
  logic [`UAB_IRQ_W-1:0] evt;
  assign evt = {ovf_evt, done};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      istat_ff <= 2'h0;
      imask_ff <= 2'h0;
      irq_ff <= 1'b0;
    end else begin
      istat_ff <= evt | (istat_ff & ~(wr_istat ? hwdata[1:0] : 2'h0));
      if (wr_imask) begin
        imask_ff <= hwdata[1:0];
      end
      irq_ff <= |(istat_ff & imask_ff);
    end
  end

  // Bit-rate tick from the divisor, halted while measuring.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rate_cnt_ff <= '0;
      tick_ff <= 1'b0;
      hold_ff <= 1'b0;
    end else begin
      hold_ff <= ctrl_ff.en; // see [R02]
      tick_ff <= 1'b0;
      if (ctrl_ff.en) begin
        rate_cnt_ff <= '0;
      end else if (base_tick) begin
        if (rate_cnt_ff >= div_ff) begin
          rate_cnt_ff <= '0;
          tick_ff <= 1'b1; // see [R17]
        end else begin
          rate_cnt_ff <= rate_cnt_ff + DIV_W'(1);
        end
      end
    end
  end

  // Read data is registered in the address phase, so there are no wait states.
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (haddr[31:6] != 26'h0) begin
      rmux = 32'h0000_0000;
    end else if (ra == `UAB_OFS_CTRL) begin
      rmux = {27'h0, ctrl_ff};
    end else if (ra == `UAB_OFS_DIV) begin
      rmux = 32'(div_ff); // see [R11]
    end else if (ra == `UAB_OFS_STATUS) begin
      rmux = {29'h0, state_ff != UAB_IDLE, hold_ff, rif_ff};
    end else if (ra == `UAB_OFS_ISTAT) begin
      rmux = {30'h0, istat_ff};
    end else if (ra == `UAB_OFS_IMASK) begin
      rmux = {30'h0, imask_ff};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_ff <= 32'h0000_0000;
      hready_ff <= 1'b0;
    end else begin
      hready_ff <= 1'b1;
      if (rd_acc) begin
        hrdata_ff <= rmux;
      end
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign rx_hold = hold_ff;
  assign rate_tick = tick_ff;
  assign irq = irq_ff;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence fifth_edge_s;
    state_ff == UAB_COUNT && rx_rise && edges_ff == 3'h1;
  endsequence

  sequence start_count_s;
    state_ff == UAB_FIRST_RISE && rx_rise && ctrl_ff.en && !abort;
  endsequence

  done_clears_en_a: assert property (fifth_edge_s |=> // see [R05]
    !ctrl_ff.en && rif_ff && state_ff == UAB_IDLE)
    else $error("completion did not clear enable or set receive flag");
  start_loads_one_a: assert property (start_count_s |=> // see [R10]
    div_ff == DIV_W'(1) && state_ff == UAB_COUNT)
    else $error("counter did not start at one");
  count_step_a: assert property (state_ff == UAB_COUNT && abd_tick && !rx_rise // see [R07]
    |=> div_ff == $past(div_ff) + DIV_W'(1))
    else $error("counter did not step on measuring tick");
  ovf_sets_a: assert property (ovf_evt |=> ctrl_ff.ovf && div_ff == '0) // see [R13]
    else $error("overflow flag not set on wrap");
  ovf_kept_done_a: assert property (fifth_edge_s ##0 ctrl_ff.ovf |=> ctrl_ff.ovf) // see [R15]
    else $error("overflow flag cleared at completion");
  tick_halt_a: assert property (ctrl_ff.en |=> !tick_ff) // see [R02]
    else $error("rate tick ran during measurement");
  wake_first_a: assert property (state_ff == UAB_IDLE && ctrl_ff.en && ctrl_ff.wake // see [R12]
    && !abort |=> state_ff == UAB_WAKE_FALL)
    else $error("wake mode did not wait for the break first");
  ovf_held_a: assert property (ctrl_ff.ovf && ctrl_ff.en |=> ctrl_ff.ovf) // see [R16]
    else $error("overflow flag cleared while enabled");
  rif_read_a: assert property (rd_rx && !done |=> !rif_ff) // see [R06]
    else $error("receive flag not cleared by data read");
  hold_idle_a: assert property (ctrl_ff.en |=> hold_ff) // see [R02]
    else $error("receiver not held idle during measurement");
  abd_in_base_a: assert property (abd_tick |-> base_tick) // see [R08]
    else $error("measuring tick not aligned to base tick");
  irq_level_a: assert property (|(istat_ff & imask_ff) |=> irq) // see [R14]
    else $error("interrupt not raised for unmasked status");

endmodule : uab_autobaud

// *** common/uab_params.svh ***
// Register map, field positions, reset values and timing counts of the auto-baud unit.
`ifndef UAB_PARAMS_SVH
`define UAB_PARAMS_SVH
`define UAB_OFS_CTRL 6'h00
`define UAB_OFS_DIV 6'h04
`define UAB_OFS_RXDATA 6'h08
`define UAB_OFS_STATUS 6'h0C
`define UAB_OFS_ISTAT 6'h10
`define UAB_OFS_IMASK 6'h14
`define UAB_CTRL_W 5
`define UAB_CTRL_RST 5'h00
`define UAB_DIV_RST 16'h0000
`define UAB_DIV_START 16'h0001
`define UAB_DIV_MAX 16'hFFFF
`define UAB_EDGES_LEFT 3'h4
`define UAB_IRQ_DONE 0
`define UAB_IRQ_OVF 1
`define UAB_IRQ_W 2
`define UAB_PRE_W 9
`define UAB_BASE_M00 9'h03F
`define UAB_BASE_M01 9'h00F
`define UAB_BASE_M11 9'h003
`define UAB_ABD_M00 9'h1FF
`define UAB_ABD_M01 9'h07F
`define UAB_ABD_M11 9'h01F
`endif

// *** common/uab_pkg.sv ***
// Types shared by the auto-baud unit.
package uab_pkg;
  typedef enum logic [2:0] {
    UAB_IDLE,
    UAB_WAKE_FALL,
    UAB_WAKE_RISE,
    UAB_START,
    UAB_FIRST_RISE,
    UAB_COUNT
  } uab_state_type;

  typedef struct packed {
    logic ovf;
    logic speed;
    logic wide;
    logic wake;
    logic en;
  } uab_ctrl_type;
endpackage : uab_pkg

// *** bench/uab_tx_model.sv ***
// Remote serial transmitter model driving the receive line.
`timescale 1ns/1ns
module uab_tx_model (
  // Clock.
  input wire logic hclk,
  // Serial line, idle high.
  output logic rx_pin
);
  initial rx_pin = 1'b1;

  task automatic hold_line(input logic lvl, input int cycles);
    @(posedge hclk);
    rx_pin <= lvl;
    repeat (cycles - 1) @(posedge hclk);
  endtask : hold_line

  // Sends a character least significant bit first, then the high stop bit.
  task automatic send_char(input logic [7:0] chr, input int bit_cycles);
    hold_line(1'b0, bit_cycles);
    for (int i = 0; i < 8; i++) begin
      hold_line(chr[i], bit_cycles);
    end
    hold_line(1'b1, bit_cycles);
  endtask : send_char
endmodule : uab_tx_model

// *** bench/tb_uab_autobaud.sv ***
// Self-checking bench of the auto-baud unit.
`timescale 1ns/1ns
`include "uab_params.svh"
module tb_uab_autobaud;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rx_pin, rx_hold, rate_tick, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [25:0] page;
  int n_mismatch = 0;
  int checks_done = 0;
  int abd_div [4] = '{512, 128, 128, 32};
  int base_div [4] = '{64, 16, 16, 4};
  int gap;

  // A short divisor lets the overflow path run within the bench's time budget.
  uab_autobaud #(.DIV_W(8)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rx_pin(rx_pin),
    .rx_hold(rx_hold), .rate_tick(rate_tick), .irq(irq));
  uab_tx_model tx (.hclk(hclk), .rx_pin(rx_pin));

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [5:0] ofs, input logic [31:0] wdat);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {page, ofs};
    hwrite <= wr;
    htrans <= 2'h2;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wdat;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [5:0] ofs, input logic [31:0] d);
    bus(1'b1, ofs, d);
  endtask : wr

  task automatic rdc(input string what, input logic [5:0] ofs, input logic [31:0] exp);
    bus(1'b0, ofs, 32'h0);
    check(what, rd, exp);
  endtask : rdc

  // Reads the divisor and compares the measured count, allowing one tick of phase.
  task automatic chk_div(input int n);
    logic [15:0] meas;
    bus(1'b0, `UAB_OFS_DIV, 32'h0);
    meas = rd[15:0] - 16'h0001;
    check("div_meas", (meas >= n - 1 && meas <= n + 1) ? n : meas, n);
    check("div_high", rd[15:8], 32'h0);
  endtask : chk_div

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  initial begin
    repeat (100000) @(posedge hclk);
    n_mismatch++;
    summarize();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    page = 26'h0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("ctrl_rst", `UAB_OFS_CTRL, 32'h0);
    rdc("div_rst", `UAB_OFS_DIV, 32'h0);
    rdc("status_rst", `UAB_OFS_STATUS, 32'h0);
    page = 26'h1;
    wr(`UAB_OFS_CTRL, 32'h1);
    rdc("unmapped", `UAB_OFS_CTRL, 32'h0);
    page = 26'h0;
    rdc("ctrl_kept", `UAB_OFS_CTRL, 32'h0);
    wr(`UAB_OFS_IMASK, 32'h1);
    wr(`UAB_OFS_DIV, 32'h3);
    for (int m = 0; m < 4; m++) begin
      wr(`UAB_OFS_CTRL, {28'h0, m[0], m[1], 2'h0});
      while (rate_tick !== 1'b1) @(posedge hclk);
      @(posedge hclk);
      gap = 1;
      while (rate_tick !== 1'b1 && gap < 2000) begin
        @(posedge hclk);
        gap++;
      end
      check("tick_gap", gap, 4 * base_div[m]);
    end
    for (int m = 0; m < 4; m++) begin
      wr(`UAB_OFS_CTRL, {28'h0, m[0], m[1], 2'h1});
      rdc("status_busy", `UAB_OFS_STATUS, 32'h6);
      check("rx_hold", rx_hold, 32'h1);
      tx.send_char(8'h55, abd_div[m] * 20 / 8);
      rdc("ctrl_done", `UAB_OFS_CTRL, {28'h0, m[0], m[1], 2'h0});
      chk_div(20);
      rdc("status_done", `UAB_OFS_STATUS, 32'h1);
      check("irq_on", irq, 32'h1);
      rdc("istat_done", `UAB_OFS_ISTAT, 32'h1);
      rdc("rxdata", `UAB_OFS_RXDATA, 32'h0);
      rdc("status_clr", `UAB_OFS_STATUS, 32'h0);
      wr(`UAB_OFS_ISTAT, 32'h1);
      repeat (2) @(posedge hclk);
      check("irq_off", irq, 32'h0);
    end
    wr(`UAB_OFS_CTRL, 32'hF);
    tx.hold_line(1'b0, 800);
    tx.hold_line(1'b1, 80);
    tx.send_char(8'h55, 80);
    chk_div(20);
    rdc("ctrl_wake", `UAB_OFS_CTRL, 32'hE);
    rdc("rxdata_w", `UAB_OFS_RXDATA, 32'h0);
    wr(`UAB_OFS_CTRL, 32'hD);
    tx.send_char(8'h55, 1200);
    rdc("ctrl_ovf", `UAB_OFS_CTRL, 32'h1C);
    rdc("status_ovf", `UAB_OFS_STATUS, 32'h1);
    rdc("istat_ovf", `UAB_OFS_ISTAT, 32'h3);
    chk_div(44);
    rdc("rxdata_o", `UAB_OFS_RXDATA, 32'h0);
    wr(`UAB_OFS_CTRL, 32'h1D);
    tx.hold_line(1'b0, 80);
    tx.hold_line(1'b1, 160);
    wr(`UAB_OFS_CTRL, 32'hD);
    rdc("ovf_kept_en", `UAB_OFS_CTRL, 32'h1D);
    wr(`UAB_OFS_CTRL, 32'hC);
    rdc("ovf_kept_abort", `UAB_OFS_CTRL, 32'h1C);
    wr(`UAB_OFS_CTRL, 32'hC);
    rdc("ctrl_abort", `UAB_OFS_CTRL, 32'hC);
    rdc("status_abort", `UAB_OFS_STATUS, 32'h0);
    check("hresp", hresp, 32'h0);
    summarize();
  end
endmodule : tb_uab_autobaud
